// file: common/ptm_pkg.sv
// Shared constants, register map and carrier types of the period timer block
package ptm_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DUTY = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PWMCTL = 8'h18;

  // Field positions
  localparam int CTL_PRESCALE_LSB = 0;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_POST_LSB = 3;
  localparam int CTL_USED_W = 7;
  localparam int FLAG_MATCH_BIT = 1;
  localparam int PWMCTL_MODE_LSB = 0;
  localparam int PWMCTL_DUTYLSB_LSB = 4;
  localparam int PWMCTL_USED_W = 6;

  // Reset values
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] PWMCTL_RESET = 8'h00;

  // Timing: the instruction clock is the block clock divided by four
  localparam int PHASE_W = 2;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;

  // Prescaler terminal counts for 1:1, 1:4 and 1:16
  localparam logic [3:0] PRE_LIM_1 = 4'h0;
  localparam logic [3:0] PRE_LIM_4 = 4'h3;
  localparam logic [3:0] PRE_LIM_16 = 4'hf;

  // Mode bits 3:2 both set select PWM
  localparam logic [1:0] PWM_MODE_HI = 2'h3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ptm_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } ptm_apb_rsp_t;

  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic [7:0] count;
    logic [7:0] period;
    logic [7:0] control;
    logic [7:0] flags;
    logic [7:0] mask;
    logic [7:0] dutyHigh;
    logic [7:0] pwmControl;
    logic matchPulse;
    logic [DATA_W-1:0] prdata;
    logic pslverr;
  } ptm_state_t;

  function automatic logic [3:0] prescaleLimit(input logic [1:0] sel);
    logic [3:0] lim;
    lim = PRE_LIM_16;
    if (sel == 2'h0)
    begin
      lim = PRE_LIM_1;
    end
    else if (sel == 2'h1)
    begin
      lim = PRE_LIM_4;
    end
    return lim;
  endfunction

endpackage

// file: src/ptm_scaler.sv
// Clearable event divider used as prescaler and postscaler
`timescale 1ns/10ps
module ptm_scaler #(
  parameter int W = 4
) (
  input wire logic clock,
  input wire logic rstSyncN,
  input wire logic clear,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic done
);
  import ptm_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } ptm_scaler_state_t;

  ptm_scaler_state_t state;
  ptm_scaler_state_t next_state;

  if (W < 1 || W > 16)
  begin : gWidthCheck
    $error("ptm_scaler width out of range");
  end

  // Greater-or-equal so a limit lowered mid-count still terminates
  assign done = tick && !clear && (state.cnt >= limit); // see R15

  always_comb
  begin
    next_state = state;
    if (clear)
    begin
      next_state.cnt = '0; // see R7
    end
    else if (tick)
    begin
      if (state.cnt >= limit)
      begin
        next_state.cnt = '0; // see R15
      end
      else
      begin
        next_state.cnt = state.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule // ptm_scaler

// file: src/ptm_pwm.sv
// Pulse-width output stage timed by the period timer
`timescale 1ns/10ps
module ptm_pwm (
  input wire logic clock,
  input wire logic rstSyncN,
  input wire logic enable,
  input wire logic periodStart,
  input wire logic [9:0] countExt,
  input wire logic [9:0] duty,
  output logic pwmOut
);
  import ptm_pkg::*;

  typedef struct packed {
    logic [9:0] dutyLatched;
    logic out;
  } ptm_pwm_state_t;

  ptm_pwm_state_t state;
  ptm_pwm_state_t next_state;

  assign pwmOut = state.out;

  always_comb
  begin
    next_state = state;
    if (!enable)
    begin
      next_state.out = 1'b0;
      next_state.dutyLatched = duty;
    end
    else if (periodStart)
    begin
      // While enabled, duty is taken only at a period boundary so a write never glitches a pulse
      next_state.dutyLatched = duty; // see R10
      next_state.out = (duty != 10'h000);
    end
    else if (state.out && (({1'b0, countExt} + 11'h001) >= {1'b0, state.dutyLatched}))
    begin
      // Compared one count ahead so the registered pin is low from the count equal to duty
      // A duty beyond the last count of the period is never reached
      next_state.out = 1'b0; // see R11
    end
  end

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule // ptm_pwm

// file: src/ptm_timer.sv
// Period timer with prescaler, postscaler, PWM stage and APB register slave
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps

// Functional notes
// R1: Counter runs from clock/4 through a 1:1, 1:4 or 1:16 prescaler, control bits 1:0.
// R2: Counter counts up from zero and wraps to zero after equalling the period.
// R3: Period register is read/write and resets to all ones.
// R4: Software reads and writes the counter; every reset clears it.
// R5: Match events pass a 4-bit postscaler, 1:1 to 1:16, setting the match flag.
// R6: Clearing the run bit, control bit 2, stops the timer.
// R7: Count write, control write and reset clear both scaler counters.
// R8: A control write leaves the counter value untouched.
// R9: The raw match pulse, before the postscaler, goes to the serial port.
// R10: The timer is the period time base of the PWM stage.
// R11: A duty above the period never drives the PWM output low.
// R12: Software sets period, duty, pin direction, timer, then PWM mode, in that order.
// R13: PWM resolution equals log2 of oscillator over PWM frequency.
// R14: Software picks the port B direction bit by the pin-select setting.
// R15: Postscaler flags after setting plus one matches, then restarts.
// R16: With run clear the count holds, no matches occur, registers stay reachable.
module ptm_timer (
  input wire logic clock,
  input wire logic rstn,
  input wire ptm_pkg::ptm_apb_req_t apbReq,
  output ptm_pkg::ptm_apb_rsp_t apbRsp,
  output logic irq,
  output logic sspShiftTick,
  output logic pwmOut,
  output logic pwmMode
);
  import ptm_pkg::*;

  logic [1:0] rstSync;
  logic rstSyncN;

  ptm_state_t state;
  ptm_state_t next_state;

  logic setupPhase;
  logic accessPhase;
  logic wrAccess;
  logic wrCount;
  logic wrPeriod;
  logic wrControl;
  logic wrFlags;
  logic wrMask;
  logic wrDuty;
  logic wrPwmCtl;
  logic addrMapped;
  logic [7:0] wrByte;
  logic runOn;
  logic instrTick;
  logic preTick;
  logic timerTick;
  logic matchNow;
  logic scalerClear;
  logic postDone;
  logic [9:0] dutyValue;
  logic [9:0] countExt;

  // Reset enters asynchronously but is released through two stages
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rstSync <= 2'h0;
    end
    else
    begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  assign rstSyncN = rstSync[1];

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (addr)
      OFS_COUNT, OFS_PERIOD, OFS_CONTROL, OFS_FLAGS, OFS_MASK, OFS_DUTY, OFS_PWMCTL:
      begin
        hit = 1'b1;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  function automatic logic [DATA_W-1:0] readMux(input ptm_state_t s, input logic [ADDR_W-1:0] addr);
    logic [7:0] val;
    val = 8'h00;
    unique case (addr)
      OFS_COUNT:
      begin
        val = s.count;
      end
      OFS_PERIOD:
      begin
        val = s.period;
      end
      OFS_CONTROL:
      begin
        val = s.control;
      end
      OFS_FLAGS:
      begin
        val = s.flags;
      end
      OFS_MASK:
      begin
        val = s.mask;
      end
      OFS_DUTY:
      begin
        val = s.dutyHigh;
      end
      OFS_PWMCTL:
      begin
        val = s.pwmControl;
      end
      default:
      begin
        val = 8'h00;
      end
    endcase
    return {24'h000000, val};
  endfunction

  // Bus decode; the slave never stretches the access phase
  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessPhase = apbReq.psel && apbReq.penable;
  assign wrAccess = accessPhase && apbReq.pwrite;
  assign wrByte = apbReq.pwdata[7:0];
  assign addrMapped = isMapped(apbReq.paddr);
  assign wrCount = wrAccess && (apbReq.paddr == OFS_COUNT);
  assign wrPeriod = wrAccess && (apbReq.paddr == OFS_PERIOD);
  assign wrControl = wrAccess && (apbReq.paddr == OFS_CONTROL);
  assign wrFlags = wrAccess && (apbReq.paddr == OFS_FLAGS);
  assign wrMask = wrAccess && (apbReq.paddr == OFS_MASK);
  assign wrDuty = wrAccess && (apbReq.paddr == OFS_DUTY);
  assign wrPwmCtl = wrAccess && (apbReq.paddr == OFS_PWMCTL);

  assign apbRsp.pready = accessPhase;
  assign apbRsp.prdata = state.prdata;
  assign apbRsp.pslverr = accessPhase && state.pslverr;

  // Timing chain: clock/4, then prescaler, then counter
  assign runOn = state.control[CTL_RUN_BIT];
  assign instrTick = runOn && (state.phase == PHASE_LAST); // see R1 see R6
  assign scalerClear = wrCount || wrControl; // see R7

  ptm_scaler #(
    .W(4)
  ) uPrescale (
    .clock(clock),
    .rstSyncN(rstSyncN),
    .clear(scalerClear),
    .tick(instrTick),
    .limit(prescaleLimit(state.control[CTL_PRESCALE_LSB +: 2])), // see R1
    .done(preTick)
  );

  // A count write takes priority over the increment it coincides with
  assign timerTick = preTick && !wrCount;
  assign matchNow = timerTick && (state.count == state.period); // see R2 see R16

  ptm_scaler #(
    .W(4)
  ) uPostscale (
    .clock(clock),
    .rstSyncN(rstSyncN),
    .clear(scalerClear),
    .tick(matchNow),
    .limit(state.control[CTL_POST_LSB +: 4]), // see R5 see R15
    .done(postDone)
  );

  // Extended count: low bits come from the clock/4 phase, exact only at prescale 1:1
  assign countExt = {state.count, state.phase}; // see R13
  assign dutyValue = {state.dutyHigh, state.pwmControl[PWMCTL_DUTYLSB_LSB +: 2]};
  assign pwmMode = (state.pwmControl[PWMCTL_MODE_LSB + 2 +: 2] == PWM_MODE_HI);

  ptm_pwm uPwm (
    .clock(clock),
    .rstSyncN(rstSyncN),
    .enable(pwmMode),
    .periodStart(matchNow), // see R10
    .countExt(countExt),
    .duty(dutyValue),
    .pwmOut(pwmOut)
  );

  assign sspShiftTick = state.matchPulse;
  assign irq = |(state.flags & state.mask);

  always_comb
  begin
    next_state = state;
    next_state.phase = state.phase + PHASE_W'(1);
    next_state.matchPulse = matchNow; // see R9

    if (wrCount)
    begin
      next_state.count = wrByte; // see R4
    end
    else if (timerTick)
    begin
      if (state.count == state.period)
      begin
        next_state.count = COUNT_RESET; // see R2
      end
      else
      begin
        next_state.count = state.count + 8'h01;
      end
    end

    if (wrPeriod)
    begin
      next_state.period = wrByte; // see R3
    end

    // A control write reloads control and clears both scaler counters; the counter keeps the value it holds
    if (wrControl)
    begin
      next_state.control = {1'b0, wrByte[CTL_USED_W-1:0]}; // see R8
    end

    if (wrMask)
    begin
      next_state.mask = wrByte & (8'h01 << FLAG_MATCH_BIT);
    end

    if (wrDuty)
    begin
      next_state.dutyHigh = wrByte;
    end

    if (wrPwmCtl)
    begin
      next_state.pwmControl = {2'h0, wrByte[PWMCTL_USED_W-1:0]};
    end

    // Write one clears; a flag raised in the same cycle survives the clear
    if (wrFlags)
    begin
      next_state.flags = state.flags & ~wrByte;
    end
    if (postDone)
    begin
      next_state.flags[FLAG_MATCH_BIT] = 1'b1; // see R5
    end

    // Read data and error are captured in the setup cycle for a zero-wait access phase
    if (setupPhase)
    begin
      next_state.prdata = readMux(state, apbReq.paddr);
      next_state.pslverr = !addrMapped;
    end
  end

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state.phase <= '0;
      state.count <= COUNT_RESET; // see R4
      state.period <= PERIOD_RESET; // see R3
      state.control <= CONTROL_RESET;
      state.flags <= FLAGS_RESET;
      state.mask <= MASK_RESET;
      state.dutyHigh <= DUTY_RESET;
      state.pwmControl <= PWMCTL_RESET;
      state.matchPulse <= 1'b0;
      state.prdata <= '0;
      state.pslverr <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule // ptm_timer

// file: testbench/ptm_timer_monitor.sv
// Port-level checks of the period timer
`timescale 1ns/10ps
module ptm_timer_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire ptm_pkg::ptm_apb_req_t apbReq,
  input wire ptm_pkg::ptm_apb_rsp_t apbRsp,
  input wire logic irq,
  input wire logic sspShiftTick,
  input wire logic pwmOut,
  input wire logic pwmMode
);
  import ptm_pkg::*;
  logic acc;
  logic wrAcc;
  assign acc = apbReq.psel && apbReq.penable;
  assign wrAcc = acc && apbReq.pwrite;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  ready_zero_wait_a: assert property (acc == apbRsp.pready)
    else $error("pready not tied to access phase");
  err_unmapped_a: assert property (acc |-> apbRsp.pslverr ==
    (apbReq.paddr > OFS_PWMCTL || apbReq.paddr[1:0] != 2'h0))
    else $error("pslverr wrong for address");
  read_upper_zero_a: assert property (acc && !apbReq.pwrite |-> apbRsp.prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  tick_spacing_a: assert property ($rose(sspShiftTick) |=> !sspShiftTick [*3])
    else $error("match pulses closer than four clocks");
  irq_cause_a: assert property ($rose(irq) && !$past(wrAcc) |-> ##[0:1] sspShiftTick)
    else $error("irq rose without a match");
  irq_fall_a: assert property ($fell(irq) |-> $past(wrAcc))
    else $error("irq fell without a write");
  mode_write_a: assert property (wrAcc && apbReq.paddr == OFS_PWMCTL
    |=> pwmMode == ($past(apbReq.pwdata[3:2]) == PWM_MODE_HI))
    else $error("pwm mode not taken from write");
  mode_off_low_a: assert property (!pwmMode && !$past(pwmMode) |-> !pwmOut)
    else $error("pwm output high with mode off");
endmodule // ptm_timer_monitor

bind ptm_timer ptm_timer_monitor u_mon (.clock(clock), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp),
  .irq(irq), .sspShiftTick(sspShiftTick), .pwmOut(pwmOut), .pwmMode(pwmMode));

// file: testbench/ptm_far_model.sv
// Far-side model: serial port shift clock and PWM pin observer
`timescale 1ns/10ps
module ptm_far_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sspShiftTick,
  input wire logic pwmOut,
  input wire logic pwmMode,
  output logic [15:0] shiftEdges,
  output logic [15:0] highCycles
);
  // Each raw match is one shift clock edge
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      shiftEdges <= 16'h0;
      highCycles <= 16'h0;
    end
    else
    begin
      shiftEdges <= shiftEdges + 16'(sspShiftTick);
      highCycles <= highCycles + 16'(pwmOut && pwmMode);
    end
  end
endmodule // ptm_far_model

// file: testbench/test_period_timer_with_scalers.sv
// Self-checking bench of the period timer
`timescale 1ns/10ps
module test_period_timer_with_scalers;
  import ptm_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} ptm_row_t;
  logic clock;
  logic rstn;
  ptm_apb_req_t apbReq;
  ptm_apb_rsp_t apbRsp;
  logic irq, sspShiftTick, pwmOut, pwmMode, er;
  logic [15:0] shiftEdges, highCycles, s0;
  logic [31:0] rd;
  int n_errors, checks_done, n, k;
  ptm_row_t rows [8] = '{'{OFS_PERIOD, 8'h5a, 8'h5a, 1'b0}, '{OFS_CONTROL, 8'hfb, 8'h7b, 1'b0},
    '{OFS_COUNT, 8'h33, 8'h33, 1'b0}, '{OFS_MASK, 8'hff, 8'h02, 1'b0}, '{OFS_DUTY, 8'ha5, 8'ha5, 1'b0},
    '{OFS_PWMCTL, 8'hff, 8'h3f, 1'b0}, '{OFS_FLAGS, 8'h02, 8'h00, 1'b0}, '{8'h1c, 8'h12, 8'h00, 1'b1}};

  ptm_timer u_dut (.clock(clock), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp), .irq(irq),
    .sspShiftTick(sspShiftTick), .pwmOut(pwmOut), .pwmMode(pwmMode));
  ptm_far_model u_far (.clock(clock), .rstn(rstn), .sspShiftTick(sspShiftTick), .pwmOut(pwmOut),
    .pwmMode(pwmMode), .shiftEdges(shiftEdges), .highCycles(highCycles));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic end_sim();
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x)
    begin
      n_errors++;
      $display("ERROR %0t: got %h want %h", $time, s, x);
    end
  endtask

  task automatic hang();
    n_errors++;
    end_sim();
  endtask

  // Setup then access; pready, read data and error are taken at one rising edge, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clock);
    apbReq <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clock);
      i++;
    end
    while (apbRsp.pready !== 1'b1 && i < 20);
    if (i >= 20)
      hang();
    rd = apbRsp.prdata;
    er = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h0);
    chk(rd, {24'h0, x});
  endtask

  task automatic waitTick(output int c);
    c = 0;
    do
    begin
      @(negedge clock);
      c++;
    end
    while (sspShiftTick !== 1'b1 && c < 2000);
    if (c >= 2000)
      hang();
  endtask

  initial
  begin
    apbReq = '0;
    rstn = 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 8'h0);
      chk(rd, {24'h0, rows[i].q});
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    apb(1'b1, OFS_PERIOD, 8'h03);
    apb(1'b1, OFS_COUNT, 8'h00);
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, OFS_CONTROL, 8'h04 | 8'(k));
      waitTick(n);
      waitTick(n);
      chk(n, k == 0 ? 16 : k == 1 ? 64 : 256);
    end
    // Stop first so no match is in flight when the baseline is taken
    apb(1'b1, OFS_CONTROL, 8'h10);
    apb(1'b1, OFS_FLAGS, 8'h02);
    s0 = shiftEdges;
    apb(1'b1, OFS_CONTROL, 8'h14);
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (irq !== 1'b1 && n < 200);
    if (n >= 200)
      hang();
    repeat (3) @(negedge clock);
    chk(16'(shiftEdges - s0), 3);
    rdc(OFS_FLAGS, 8'h02);
    // The write lands at the edge the task returns on, so look half a cycle later
    apb(1'b1, OFS_MASK, 8'h00);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_MASK, 8'h02);
    @(negedge clock);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_FLAGS, 8'h02);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_CONTROL, 8'h00);
    apb(1'b1, OFS_COUNT, 8'h02);
    apb(1'b1, OFS_CONTROL, 8'h78);
    s0 = shiftEdges;
    repeat (50) @(posedge clock);
    rdc(OFS_COUNT, 8'h02);
    chk({16'h0, shiftEdges}, {16'h0, s0});
    apb(1'b1, OFS_PERIOD, 8'h00);
    apb(1'b1, OFS_CONTROL, 8'h06);
    repeat (40) @(posedge clock);
    apb(1'b1, OFS_COUNT, 8'h00);
    waitTick(n);
    chk({31'h0, n >= 62 && n <= 67}, 32'h1);
    // Setup order: period, duty, direction, timer, then mode
    apb(1'b1, OFS_PERIOD, 8'h03);
    for (k = 1; k < 5; k += 3)
    begin
      apb(1'b1, OFS_DUTY, 8'(k));
      apb(1'b1, OFS_PWMCTL, 8'h00);
      // Pin direction bit choice by pin select is software outside this block
      apb(1'b1, OFS_CONTROL, 8'h04);
      apb(1'b1, OFS_PWMCTL, 8'h0c);
      repeat (40) @(posedge clock);
      s0 = highCycles;
      repeat (160) @(posedge clock);
      chk(16'(highCycles - s0), k == 1 ? 40 : 160);
    end
    apb(1'b1, OFS_PWMCTL, 8'h00);
    repeat (2) @(negedge clock);
    chk({31'h0, pwmOut}, 32'h0);
    apb(1'b1, OFS_PERIOD, 8'h10);
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    chk({29'h0, irq, sspShiftTick, pwmOut}, 32'h0);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    rdc(OFS_PERIOD, 8'hff);
    rdc(OFS_COUNT, 8'h00);
    rdc(OFS_CONTROL, 8'h00);
    end_sim();
  end
endmodule // test_period_timer_with_scalers
